// File: ate_core.sv
// Alarm type evaluator top: APB register file, alarm type decode, range
// corner cases, standby sequence and a masked interrupt.
// Assumes samples arrive as one-cycle strobes synchronous to clk.
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ate_core (
   // Clock, reset and enable
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Controller sample
   input wire logic sampleValid,
   input wire ate_pkg::ate_sample_s sample,
   // Alarm and interrupt
   output logic alarmFlag,
   output logic irq
);
   import ate_pkg::*;

   ate_state_s state_reg;
   ate_state_s state_next;
   ate_flags_s flags;
   logic setupPhase;
   logic accessDone;
   logic addrOk;
   logic [7:0] addrLow;
   logic hNeg;
   logic lNeg;
   logic hPos;
   logic lPos;
   logic [16:0] absH;
   logic [16:0] absL;
   logic degenerate;
   logic overlap;
   logic isStandbyType;
   logic rawAlarm;
   logic forcedOn;
   logic forcedOff;
   logic newAlarm;
   logic [ATE_INT_W-1:0] events;
   logic [31:0] rdValue;

   // ------------------------------------------------------------------
   // Comparator stage
   // ------------------------------------------------------------------
   ate_eval u_eval (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .sampleValid(sampleValid),
      .sample(sample),
      .cfg(state_reg.cfg),
      .flags(flags)
   );

   // ------------------------------------------------------------------
   // Offset corner cases
   // ------------------------------------------------------------------
   // The same sign and magnitude test drives types 1, 4 and 5, so it is
   // computed once; separate upper and lower offsets feed it.
   always_comb begin
      hNeg = state_reg.cfg.upperOff < 0;
      lNeg = state_reg.cfg.lowerOff < 0;
      hPos = state_reg.cfg.upperOff > 0;
      lPos = state_reg.cfg.lowerOff > 0;
      absH = hNeg ? 17'(-ate_ext(state_reg.cfg.upperOff)) : 17'(ate_ext(state_reg.cfg.upperOff));
      absL = lNeg ? 17'(-ate_ext(state_reg.cfg.lowerOff)) : 17'(ate_ext(state_reg.cfg.lowerOff));
      degenerate = (hNeg && lNeg) ||
         (hNeg && lPos && (absH >= absL)) ||
         (hPos && lNeg && (absH <= absL));
      // Band width below twice the hysteresis means both bands overlap.
      overlap = ate_add(state_reg.cfg.upperOff, state_reg.cfg.lowerOff) <
         ate_add(state_reg.cfg.hyst, state_reg.cfg.hyst);
   end

   // ------------------------------------------------------------------
   // Alarm type decode
   // ------------------------------------------------------------------
   // Types 12 and 13 and unused codes never raise the alarm here, since
   // their functions live outside this block.
   always_comb begin
      rawAlarm = 1'b0;
      forcedOn = 1'b0;
      forcedOff = 1'b0;
      isStandbyType = 1'b0;
      case (state_reg.cfg.alarmType)
         ATE_T_OFF: begin
            forcedOff = 1'b1;
         end
         ATE_T_BAND_OUT: begin
            rawAlarm = flags.pvAboveBand || flags.pvBelowBand;
            forcedOn = degenerate;
         end
         ATE_T_DEV_HIGH: begin
            rawAlarm = flags.pvDevHigh;
         end
         ATE_T_DEV_LOW: begin
            rawAlarm = flags.pvDevLow;
         end
         ATE_T_BAND_IN: begin
            rawAlarm = !flags.pvAboveBand && !flags.pvBelowBand;
            forcedOff = degenerate;
         end
         ATE_T_BAND_OUT_SB: begin
            rawAlarm = flags.pvAboveBand || flags.pvBelowBand;
            forcedOff = degenerate || overlap;
            isStandbyType = 1'b1;
         end
         ATE_T_DEV_HIGH_SB: begin
            rawAlarm = flags.pvDevHigh;
            isStandbyType = 1'b1;
         end
         ATE_T_DEV_LOW_SB: begin
            rawAlarm = flags.pvDevLow;
            isStandbyType = 1'b1;
         end
         ATE_T_ABS_HIGH: begin
            rawAlarm = flags.pvAbsHigh;
         end
         ATE_T_ABS_LOW: begin
            rawAlarm = flags.pvAbsLow;
         end
         ATE_T_ABS_HIGH_SB: begin
            rawAlarm = flags.pvAbsHigh;
            isStandbyType = 1'b1;
         end
         ATE_T_ABS_LOW_SB: begin
            rawAlarm = flags.pvAbsLow;
            isStandbyType = 1'b1;
         end
         ATE_T_SP_HIGH: begin
            rawAlarm = flags.spAbsHigh;
         end
         ATE_T_SP_LOW: begin
            rawAlarm = flags.spAbsLow;
         end
         ATE_T_MV_HIGH: begin
            rawAlarm = flags.mvAbsHigh;
         end
         ATE_T_MV_LOW: begin
            rawAlarm = flags.mvAbsLow;
         end
         default: begin
            forcedOff = 1'b1;
         end
      endcase
   end

   // ------------------------------------------------------------------
   // APB decode and read mux
   // ------------------------------------------------------------------
   // Only the low byte is decoded; any higher address bit set is an error.
   always_comb begin
      addrLow = paddr[7:0];
      setupPhase = psel && !penable;
      accessDone = psel && penable && state_reg.pready;
      addrOk = (paddr[31:8] == 24'h000000) && (paddr[1:0] == 2'h0) &&
         (addrLow <= ATE_OFF_INTMASK);
      rdValue = 32'h00000000;
      case (addrLow)
         ATE_OFF_CTRL: begin
            rdValue[ATE_CTRL_TYPE_LSB +: 5] = state_reg.cfg.alarmType;
            rdValue[ATE_CTRL_HC_BIT] = state_reg.cfg.heatCool;
         end
         ATE_OFF_ALARMVAL: rdValue[15:0] = state_reg.cfg.alarmVal;
         ATE_OFF_UPPER: rdValue[15:0] = state_reg.cfg.upperOff;
         ATE_OFF_LOWER: rdValue[15:0] = state_reg.cfg.lowerOff;
         ATE_OFF_HYST: rdValue[15:0] = state_reg.cfg.hyst;
         ATE_OFF_STATUS: begin
            rdValue[ATE_ST_ALARM_BIT] = state_reg.alarmFlag;
            rdValue[ATE_ST_ON_BIT] = forcedOn;
            rdValue[ATE_ST_OFF_BIT] = forcedOff;
            rdValue[ATE_ST_SB_BIT] = state_reg.sbState == ATE_SB_WAIT;
         end
         ATE_OFF_INTSTAT: rdValue[ATE_INT_W-1:0] = state_reg.intStat;
         ATE_OFF_INTMASK: rdValue[ATE_INT_W-1:0] = state_reg.intMask;
         default: rdValue = 32'h00000000;
      endcase
   end

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      newAlarm = state_reg.alarmFlag;
      events = '0;

      // Answer every access with one wait-free access cycle; data is captured
      // in the setup cycle so that prdata comes straight from a flop.
      state_next.pready = setupPhase;
      if (setupPhase) begin
         state_next.prdata = (addrOk && !pwrite) ? rdValue : 32'h00000000;
         state_next.pslverr = !addrOk;
      end else if (!psel) begin
         state_next.pslverr = 1'b0;
         state_next.prdata = 32'h00000000;
      end

      // Register writes take effect at the completing edge.
      if (accessDone && pwrite && addrOk) begin
         case (addrLow)
            ATE_OFF_CTRL: begin
               state_next.cfg.alarmType = pwdata[ATE_CTRL_TYPE_LSB +: 5];
               state_next.cfg.heatCool = pwdata[ATE_CTRL_HC_BIT];
               // A new type restarts the standby sequence.
               state_next.sbState = ATE_SB_WAIT;
            end
            ATE_OFF_ALARMVAL: state_next.cfg.alarmVal = pwdata[15:0];
            ATE_OFF_UPPER: state_next.cfg.upperOff = pwdata[15:0];
            ATE_OFF_LOWER: state_next.cfg.lowerOff = pwdata[15:0];
            ATE_OFF_HYST: state_next.cfg.hyst = pwdata[15:0];
            ATE_OFF_INTMASK: state_next.intMask = pwdata[ATE_INT_W-1:0];
            default: state_next.cfg = state_reg.cfg;
         endcase
      end

      // Each sample re-evaluates the selected type.
      if (flags.valid) begin
         if (forcedOn) begin
            newAlarm = 1'b1;
         end else if (forcedOff) begin
            newAlarm = 1'b0;
         end else if (isStandbyType) begin
            // Standby holds the alarm off until the first clear sample.
            case (state_reg.sbState)
               ATE_SB_WAIT: begin
                  newAlarm = 1'b0;
                  if (!rawAlarm) begin
                     state_next.sbState = ATE_SB_ARMED;
                  end
               end
               ATE_SB_ARMED: newAlarm = rawAlarm;
               default: state_next.sbState = ATE_SB_WAIT;
            endcase
         end else begin
            newAlarm = rawAlarm;
         end
      end
      state_next.alarmFlag = newAlarm;

      // Sticky events; a read clears only the bits it reported in its setup
      // cycle, so an event between setup and completion is not lost, and a
      // new event in the completing cycle wins as well.
      events[ATE_INT_RISE] = newAlarm && !state_reg.alarmFlag;
      events[ATE_INT_FALL] = !newAlarm && state_reg.alarmFlag;
      if (accessDone && !pwrite && addrOk && (addrLow == ATE_OFF_INTSTAT)) begin
         state_next.intStat = (state_reg.intStat & ~state_reg.prdata[ATE_INT_W-1:0]) | events;
      end else begin
         state_next.intStat = state_reg.intStat | events;
      end
      state_next.irq = |(state_next.intStat & state_next.intMask);
   end

   // ------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------
   // Everything freezes while ce is low, including the bus answer.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg.pready <= 1'b0;
         state_reg.pslverr <= 1'b0;
         state_reg.prdata <= 32'h00000000;
         state_reg.cfg.alarmType <= ATE_TYPE_RST;
         state_reg.cfg.heatCool <= 1'b0;
         state_reg.cfg.alarmVal <= ATE_VAL_RST;
         state_reg.cfg.upperOff <= ATE_VAL_RST;
         state_reg.cfg.lowerOff <= ATE_VAL_RST;
         state_reg.cfg.hyst <= ATE_VAL_RST;
         state_reg.intStat <= '0;
         state_reg.intMask <= ATE_MASK_RST;
         state_reg.alarmFlag <= 1'b0;
         state_reg.irq <= 1'b0;
         state_reg.sbState <= ATE_SB_WAIT;
      end else if (ce) begin
         state_reg <= state_next;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign prdata = state_reg.prdata;
   assign pready = state_reg.pready;
   assign pslverr = state_reg.pslverr;
   assign alarmFlag = state_reg.alarmFlag;
   assign irq = state_reg.irq;

endmodule
`default_nettype wire

// File: ate_core_checker.sv
// Checker of the alarm type evaluator top: APB timing and alarm decode.
// Assumes it is bound to ate_core and that the clock enable is mostly high.
`timescale 1ns/1ps
`default_nettype none
module ate_core_checker (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Sample and alarm
   input wire logic sampleValid,
   input wire ate_pkg::ate_sample_s sample,
   input wire logic alarmFlag,
   input wire logic irq
);
   import ate_pkg::*;
   logic [4:0] typ;
   logic hc;
   ate_val_t thr;
   logic badAddr;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // --------------------------------------------------------------
   // Shadow of type and threshold, taken only on accepted writes.
   // --------------------------------------------------------------
   assign badAddr = (paddr[31:8] != 24'h0) || (paddr[1:0] != 2'h0) || (paddr[7:0] > 8'h1c);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         typ <= ATE_TYPE_RST;
         hc <= 1'b0;
         thr <= ATE_VAL_RST;
      end else if (ce && psel && penable && pwrite && pready && !pslverr) begin
         if (paddr[7:0] == ATE_OFF_CTRL) begin
            typ <= pwdata[4:0];
            hc <= pwdata[8];
         end
         if (paddr[7:0] == ATE_OFF_ALARMVAL) begin
            thr <= pwdata[15:0];
         end
      end
   end
   // The alarm relations compare with the config seen at the sample edge.
   a_ready_after_setup: assert property (psel && !penable && ce |=> pready) else $error("no ready after setup");
   a_ready_one_cycle: assert property (pready && ce |=> !pready) else $error("ready held too long");
   a_err_bad_addr: assert property (psel && !penable && ce |=> pslverr == $past(badAddr)) else $error("bad error flag");
   a_err_data_zero: assert property (pslverr |-> prdata == 32'h0) else $error("data with error");
   a_flag_after_sample: assert property ($changed(alarmFlag) |-> $past(sampleValid, 2)) else $error("flag moved");
   a_sp_high: assert property (sampleValid && ce && typ == ATE_T_SP_HIGH |-> ##2
      alarmFlag == ($past(sample.targetValue, 2) > $past(thr, 2))) else $error("target high alarm wrong");
   a_sp_low: assert property (sampleValid && ce && typ == ATE_T_SP_LOW |-> ##2
      alarmFlag == ($past(sample.targetValue, 2) < $past(thr, 2))) else $error("target low alarm wrong");
   a_mv_high: assert property (sampleValid && ce && typ == ATE_T_MV_HIGH |-> ##2
      alarmFlag == ($past(sample.controlOutputLevel, 2) > $past(thr, 2))) else $error("output high alarm wrong");
   a_mv_low: assert property (sampleValid && ce && typ == ATE_T_MV_LOW |-> ##2 alarmFlag ==
      (($past(hc, 2) ? $past(sample.coolingOutputLevel, 2) : $past(sample.controlOutputLevel, 2)) < $past(thr, 2)))
      else $error("output low alarm wrong");
endmodule
`default_nettype wire

// File: ate_eval.sv
// Comparator stage of the alarm type evaluator: on each sample strobe it
// registers every comparison with the sample that any alarm type may need.
// Assumes the sample and configuration are stable in the strobe cycle.
`timescale 1ns/1ps
`default_nettype none
module ate_eval (
   // Clock, reset and enable
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Sample strobe and data
   input wire logic sampleValid,
   input wire ate_pkg::ate_sample_s sample,
   input wire ate_pkg::ate_cfg_s cfg,
   // Registered comparison results
   output ate_pkg::ate_flags_s flags
);
   import ate_pkg::*;

   ate_eval_state_s state_reg;
   ate_eval_state_s state_next;
   ate_val_t mvHigh;
   ate_val_t mvLow;

   // --------------------------------------------------------------
   // Comparisons
   // --------------------------------------------------------------
   // In heating/cooling mode the upper check uses the heating level and the
   // lower check the cooling level; a single output serves both otherwise.
   always_comb begin
      mvHigh = sample.controlOutputLevel;
      mvLow = cfg.heatCool ? sample.coolingOutputLevel : sample.controlOutputLevel;
      state_next = state_reg;
      state_next.flags.valid = sampleValid;
      if (sampleValid) begin
         // All sums are widened to 18 bits so offsets never wrap.
         state_next.flags.pvAboveBand = ate_ext(sample.measuredValue) >=
            ate_add(sample.targetValue, cfg.upperOff);
         state_next.flags.pvBelowBand = ate_ext(sample.measuredValue) <=
            ate_sub(sample.targetValue, cfg.lowerOff);
         state_next.flags.pvDevHigh = ate_ext(sample.measuredValue) >=
            ate_add(sample.targetValue, cfg.alarmVal);
         state_next.flags.pvDevLow = ate_ext(sample.measuredValue) <=
            ate_sub(sample.targetValue, cfg.alarmVal);
         state_next.flags.pvAbsHigh = sample.measuredValue > cfg.alarmVal;
         state_next.flags.pvAbsLow = sample.measuredValue < cfg.alarmVal;
         state_next.flags.spAbsHigh = sample.targetValue > cfg.alarmVal;
         state_next.flags.spAbsLow = sample.targetValue < cfg.alarmVal;
         state_next.flags.mvAbsHigh = mvHigh > cfg.alarmVal;
         state_next.flags.mvAbsLow = mvLow < cfg.alarmVal;
      end
   end

   // State register, frozen while the clock enable is low.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= '0;
      end else if (ce) begin
         state_reg <= state_next;
      end
   end

   assign flags = state_reg.flags;

endmodule
`default_nettype wire

// File: ate_pkg.sv
// Package of the alarm type evaluator: register map, field layout, reset
// values, alarm type codes and the structs that carry grouped signals.
// Assumes a single 10 MHz clock domain and 16-bit signed engineering units.
package ate_pkg;

   // ------------------------------------------------------------------
   // Register map (byte addresses on APB)
   // ------------------------------------------------------------------
   localparam logic [7:0] ATE_OFF_CTRL = 8'h00;
   localparam logic [7:0] ATE_OFF_ALARMVAL = 8'h04;
   localparam logic [7:0] ATE_OFF_UPPER = 8'h08;
   localparam logic [7:0] ATE_OFF_LOWER = 8'h0c;
   localparam logic [7:0] ATE_OFF_HYST = 8'h10;
   localparam logic [7:0] ATE_OFF_STATUS = 8'h14;
   localparam logic [7:0] ATE_OFF_INTSTAT = 8'h18;
   localparam logic [7:0] ATE_OFF_INTMASK = 8'h1c;

   // ------------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------------
   localparam int unsigned ATE_CTRL_TYPE_LSB = 0;
   localparam int unsigned ATE_CTRL_HC_BIT = 8;
   localparam int unsigned ATE_ST_ALARM_BIT = 0;
   localparam int unsigned ATE_ST_ON_BIT = 1;
   localparam int unsigned ATE_ST_OFF_BIT = 2;
   localparam int unsigned ATE_ST_SB_BIT = 3;
   localparam int unsigned ATE_INT_RISE = 0;
   localparam int unsigned ATE_INT_FALL = 1;
   localparam int unsigned ATE_INT_W = 2;
   localparam logic [4:0] ATE_TYPE_RST = 5'h02;
   localparam logic [15:0] ATE_VAL_RST = 16'h0000;
   localparam logic [ATE_INT_W-1:0] ATE_MASK_RST = 2'h0;

   // ------------------------------------------------------------------
   // Alarm type codes
   // ------------------------------------------------------------------
   localparam logic [4:0] ATE_T_OFF = 5'h00;
   localparam logic [4:0] ATE_T_BAND_OUT = 5'h01;
   localparam logic [4:0] ATE_T_DEV_HIGH = 5'h02;
   localparam logic [4:0] ATE_T_DEV_LOW = 5'h03;
   localparam logic [4:0] ATE_T_BAND_IN = 5'h04;
   localparam logic [4:0] ATE_T_BAND_OUT_SB = 5'h05;
   localparam logic [4:0] ATE_T_DEV_HIGH_SB = 5'h06;
   localparam logic [4:0] ATE_T_DEV_LOW_SB = 5'h07;
   localparam logic [4:0] ATE_T_ABS_HIGH = 5'h08;
   localparam logic [4:0] ATE_T_ABS_LOW = 5'h09;
   localparam logic [4:0] ATE_T_ABS_HIGH_SB = 5'h0a;
   localparam logic [4:0] ATE_T_ABS_LOW_SB = 5'h0b;
   localparam logic [4:0] ATE_T_SP_HIGH = 5'h0e;
   localparam logic [4:0] ATE_T_SP_LOW = 5'h0f;
   localparam logic [4:0] ATE_T_MV_HIGH = 5'h10;
   localparam logic [4:0] ATE_T_MV_LOW = 5'h11;

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef logic signed [15:0] ate_val_t;
   typedef logic signed [17:0] ate_wide_t;

   typedef struct packed {
      logic [4:0] alarmType;
      logic heatCool;
      ate_val_t alarmVal;
      ate_val_t upperOff;
      ate_val_t lowerOff;
      ate_val_t hyst;
   } ate_cfg_s;

   typedef struct packed {
      ate_val_t targetValue;
      ate_val_t measuredValue;
      ate_val_t controlOutputLevel;
      ate_val_t coolingOutputLevel;
   } ate_sample_s;

   typedef struct packed {
      logic valid;
      logic pvAboveBand;
      logic pvBelowBand;
      logic pvDevHigh;
      logic pvDevLow;
      logic pvAbsHigh;
      logic pvAbsLow;
      logic spAbsHigh;
      logic spAbsLow;
      logic mvAbsHigh;
      logic mvAbsLow;
   } ate_flags_s;

   typedef struct packed {
      ate_flags_s flags;
   } ate_eval_state_s;

   typedef enum logic [1:0] {
      ATE_SB_WAIT = 2'b01,
      ATE_SB_ARMED = 2'b10
   } ate_sb_e;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      ate_cfg_s cfg;
      logic [ATE_INT_W-1:0] intStat;
      logic [ATE_INT_W-1:0] intMask;
      logic alarmFlag;
      logic irq;
      ate_sb_e sbState;
   } ate_state_s;

   // Sign-extend and add two values without overflow.
   function automatic ate_wide_t ate_add(input ate_val_t a, input ate_val_t b);
      return {{2{a[15]}}, a} + {{2{b[15]}}, b};
   endfunction

   // Sign-extend and subtract two values without overflow.
   function automatic ate_wide_t ate_sub(input ate_val_t a, input ate_val_t b);
      return {{2{a[15]}}, a} - {{2{b[15]}}, b};
   endfunction

   // Widen one value for comparison against a sum.
   function automatic ate_wide_t ate_ext(input ate_val_t a);
      return {{2{a[15]}}, a};
   endfunction

endpackage

// File: tb_top.sv
// Self-checking bench of the alarm type evaluator top.
// Assumes ce is high except in the closing clock-enable test.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import ate_pkg::*;
   typedef struct {int t, hc, x, h, l, y, sp, pv, mv, cl, e;} ate_row_s;
   logic clk = 1'b0;
   logic rst_n, ce, psel, penable, pwrite, pready, pslverr, sampleValid, alarmFlag, irq, rerr;
   logic [31:0] paddr, pwdata, prdata, rdat;
   ate_sample_s sample;
   int errors = 0;
   int comparisons = 0;
   int cycles = 0;
   // --------------------------------------------------------------
   // Table: type, heatCool, X, H, L, hyst, target, measured, out, cool, alarm.
   // --------------------------------------------------------------
   ate_row_s rows[29] = '{
      '{14, 0, 50, 0, 0, 0, 100, 0, 0, 0, 1},
      '{14, 0, 50, 0, 0, 0, 50, 0, 0, 0, 0},
      '{14, 0, -20, 0, 0, 0, -10, 0, 0, 0, 1},
      '{15, 0, 50, 0, 0, 0, 40, 0, 0, 0, 1},
      '{15, 0, 50, 0, 0, 0, 50, 0, 0, 0, 0},
      '{16, 0, 50, 0, 0, 0, 0, 0, 60, 0, 1},
      '{16, 1, 50, 0, 0, 0, 0, 0, 40, 90, 0},
      '{16, 1, 50, 0, 0, 0, 0, 0, 60, 0, 1},
      '{17, 0, 50, 0, 0, 0, 0, 0, 40, 90, 1},
      '{17, 1, 50, 0, 0, 0, 0, 0, 90, 40, 1},
      '{17, 1, 50, 0, 0, 0, 0, 0, 40, 90, 0},
      '{1, 0, 0, 10, 10, 0, 100, 110, 0, 0, 1},
      '{1, 0, 0, 10, 10, 0, 100, 105, 0, 0, 0},
      '{1, 0, 0, 10, 10, 0, 100, 90, 0, 0, 1},
      '{1, 0, 0, -5, -5, 0, 100, 100, 0, 0, 1},
      '{1, 0, 0, -10, 5, 0, 100, 100, 0, 0, 1},
      '{1, 0, 0, 5, -10, 0, 100, 100, 0, 0, 1},
      '{4, 0, 0, 10, 10, 0, 100, 105, 0, 0, 1},
      '{4, 0, 0, 10, 20, 0, 100, 85, 0, 0, 1},
      '{4, 0, 0, 10, 10, 0, 100, 120, 0, 0, 0},
      '{4, 0, 0, -5, -5, 0, 100, 100, 0, 0, 0},
      '{5, 0, 0, -5, -5, 0, 100, 300, 0, 0, 0},
      '{5, 0, 0, 2, 2, 3, 100, 300, 0, 0, 0},
      '{6, 0, 10, 0, 0, 0, 100, 110, 0, 0, 0},
      '{2, 0, 10, 0, 0, 0, 100, 110, 0, 0, 1},
      '{3, 0, 10, 0, 0, 0, 100, 90, 0, 0, 1},
      '{8, 0, 50, 0, 0, 0, 0, 60, 0, 0, 1},
      '{9, 0, 50, 0, 0, 0, 0, 40, 0, 0, 1},
      '{0, 0, 0, 0, 0, 0, 100, 300, 0, 0, 0}};

   ate_core dut (.clk(clk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sampleValid(sampleValid), .sample(sample), .alarmFlag(alarmFlag), .irq(irq));

   always #50 clk = ~clk;

   // A hang ends the run as a mismatch rather than stalling forever.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         errors++;
         end_sim();
      end
   end

   task automatic end_sim();
      if (errors == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      comparisons++;
      if (s !== x) begin
         errors++;
         $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, s, x);
      end
   endtask

   // One APB transfer; the request is held until pready is seen high.
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   function automatic logic [31:0] v(input int a);
      return {16'h0000, a[15:0]};
   endfunction

   // One sample strobe, then wait out the fixed two-cycle latency.
   task automatic smp(input int sp, input int pv, input int mv, input int cl);
      @(posedge clk);
      sampleValid <= 1'b1;
      sample <= '{ate_val_t'(sp), ate_val_t'(pv), ate_val_t'(mv), ate_val_t'(cl)};
      @(posedge clk);
      sampleValid <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   initial begin
      {rst_n, psel, penable, pwrite, sampleValid} = 5'h00;
      ce = 1'b1;
      paddr = 32'h0;
      pwdata = 32'h0;
      sample = '0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      chk({30'h0, alarmFlag, irq}, 32'h0);
      apb(0, ATE_OFF_CTRL, 0);
      chk(rdat, 32'h2);
      apb(0, ATE_OFF_INTMASK, 0);
      chk(rdat, 32'h0);
      apb(0, 32'h20, 0);
      chk({rerr, rdat[30:0]}, 32'h80000000);
      apb(0, 32'h02, 0);
      chk({31'h0, rerr}, 32'h1);
      foreach (rows[i]) begin
         apb(1, ATE_OFF_CTRL, (rows[i].hc << 8) | rows[i].t);
         apb(1, ATE_OFF_ALARMVAL, v(rows[i].x));
         apb(1, ATE_OFF_UPPER, v(rows[i].h));
         apb(1, ATE_OFF_LOWER, v(rows[i].l));
         apb(1, ATE_OFF_HYST, v(rows[i].y));
         smp(rows[i].sp, rows[i].pv, rows[i].mv, rows[i].cl);
         chk({31'h0, alarmFlag}, 32'(rows[i].e));
         apb(0, ATE_OFF_STATUS, 0);
         chk(rdat & 32'h1, 32'(rows[i].e));
      end
      // Degenerate offsets show as forced off for type 4 and forced on for type 1.
      apb(1, ATE_OFF_CTRL, 4);
      apb(1, ATE_OFF_UPPER, v(-5));
      apb(1, ATE_OFF_LOWER, 5);
      apb(0, ATE_OFF_STATUS, 0);
      chk(rdat & 32'h6, 32'h4);
      apb(1, ATE_OFF_CTRL, 1);
      apb(0, ATE_OFF_STATUS, 0);
      chk(rdat & 32'h6, 32'h2);
      // Type 5 armed by a clear sample, then forced off by overlap or offsets.
      apb(1, ATE_OFF_CTRL, 5);
      apb(1, ATE_OFF_UPPER, 10);
      apb(1, ATE_OFF_LOWER, 10);
      smp(100, 100, 0, 0);
      smp(100, 300, 0, 0);
      chk({31'h0, alarmFlag}, 32'h1);
      apb(1, ATE_OFF_HYST, 11);
      smp(100, 300, 0, 0);
      chk({31'h0, alarmFlag}, 32'h0);
      apb(0, ATE_OFF_STATUS, 0);
      chk(rdat, 32'h4);
      apb(1, ATE_OFF_HYST, 0);
      apb(1, ATE_OFF_UPPER, v(-5));
      apb(1, ATE_OFF_LOWER, 5);
      smp(100, 300, 0, 0);
      chk({31'h0, alarmFlag}, 32'h0);
      // Interrupt: rise seen, read clears, masked fall stays quiet.
      apb(0, ATE_OFF_INTSTAT, 0);
      apb(1, ATE_OFF_CTRL, 32'he);
      apb(1, ATE_OFF_ALARMVAL, 0);
      apb(1, ATE_OFF_INTMASK, 32'h1);
      smp(10, 0, 0, 0);
      chk({31'h0, irq}, 32'h1);
      apb(0, ATE_OFF_INTSTAT, 0);
      chk(rdat, 32'h1);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      smp(-1, 0, 0, 0);
      chk({30'h0, alarmFlag, irq}, 32'h0);
      apb(0, ATE_OFF_INTSTAT, 0);
      chk(rdat, 32'h2);
      // A sample strobe while the clock enable is low must not be taken.
      ce <= 1'b0;
      smp(10, 0, 0, 0);
      chk({30'h0, alarmFlag, irq}, 32'h0);
      ce <= 1'b1;
      end_sim();
   end
endmodule

bind ate_core ate_core_checker chk_i (.clk(clk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .sampleValid(sampleValid), .sample(sample), .alarmFlag(alarmFlag), .irq(irq));
`default_nettype wire
